/* File: design/chain_frontend_pkg.sv */
// Shared constants and types for the serial port chain front end
package chain_frontend_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned HALF_LONG_NS   = 150;
    localparam int unsigned HALF_SHORT_NS  = 50;
    // Least times: round up to whole cycles
    localparam int unsigned HALF_LONG_CYC  = (HALF_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned HALF_SHORT_CYC = (HALF_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // First-level length at or above this is a long pulse
    localparam int unsigned LONG_SPLIT_CYC = (HALF_LONG_CYC + HALF_SHORT_CYC) / 2;
    localparam int unsigned CNT_W          = 5;
    localparam int unsigned ADDR_W         = 4;
    localparam int unsigned BITCNT_W       = 8;
    localparam int unsigned SYNC_W         = 13;
    // Positions in the synchronised pin vector
    localparam int unsigned SP_ISO   = 0;
    localparam int unsigned SP_CHAIN = 1;
    localparam int unsigned SP_CSB   = 2;
    localparam int unsigned SP_SCK   = 3;
    localparam int unsigned SP_SDI   = 4;
    localparam int unsigned SP_APOS  = 5;
    localparam int unsigned SP_ANEG  = 6;
    localparam int unsigned SP_BPOS  = 7;
    localparam int unsigned SP_BNEG  = 8;
    localparam int unsigned SP_ADDR  = 9;
    // Values after reset
    localparam logic [SYNC_W-1:0] SYNC_RST = 13'h001c;
    localparam logic [CNT_W-1:0]  CNT_RST  = 5'h00;

    typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_FIRST, RX_TAIL} rx_state_t;
    typedef enum logic {LINK_READY, LINK_ACTIVE} link_state_t;
endpackage

/* File: design/pulse_tx_if.sv */
// Request carrier between the link control and one pulse transmitter
`timescale 1ns/1ps
interface pulse_tx_if;
    logic req;
    logic is_long;
    logic is_neg;
    logic busy;
    modport src (output req, output is_long, output is_neg, input busy);
    modport drv (input req, input is_long, input is_neg, output busy);
endinterface

/* File: design/pulse_tx.sv */
// Two-level differential pulse transmitter
`timescale 1ns/1ps
module pulse_tx
    import chain_frontend_pkg::*;
(
    input  wire logic   clock_in,
    input  wire logic   sys_rst_in,
    input  wire logic   clk_en_in,
    pulse_tx_if.drv     tx,
    output logic        pos_out,
    output logic        neg_out
);
    tx_state_t        state_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] half_reg;
    logic             first_neg_reg;
    logic [CNT_W-1:0] half_sel;

    // Half-pulse length for the new request
    assign half_sel = tx.is_long ? CNT_W'(HALF_LONG_CYC - 1) : CNT_W'(HALF_SHORT_CYC - 1);
    assign tx.busy  = (state_reg != TX_IDLE);

    // First level, opposite level, then back to zero
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_reg     <= TX_IDLE;
            cnt_reg       <= CNT_RST;
            half_reg      <= CNT_RST;
            first_neg_reg <= 1'b0;
            pos_out       <= 1'b0;
            neg_out       <= 1'b0;
        end else if (clk_en_in) begin
            unique case (state_reg)
                TX_IDLE: begin
                    if (tx.req) begin
                        state_reg     <= TX_FIRST;
                        cnt_reg       <= half_sel;
                        half_reg      <= half_sel;
                        first_neg_reg <= tx.is_neg;
                        pos_out       <= !tx.is_neg;
                        neg_out       <= tx.is_neg;
                    end
                end
                TX_FIRST: begin
                    if (cnt_reg == CNT_RST) begin
                        state_reg <= TX_SECOND;
                        cnt_reg   <= half_reg;
                        pos_out   <= first_neg_reg;
                        neg_out   <= !first_neg_reg;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
                TX_SECOND: begin
                    if (cnt_reg == CNT_RST) begin
                        state_reg <= TX_IDLE;
                        pos_out   <= 1'b0;
                        neg_out   <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end
            endcase
        end
    end
endmodule

/* File: design/serial_port_chain_frontend.sv */
// Serial port front end: SPI or pulse link on port A, chain relay to port B
// Operation
// [RULE_01] Interface strap low gives a 4-wire SPI slave on port A, high a pulse link.
// [RULE_02] Topology strap high gives a two-port daisy chain, low a parallel addressed bus.
// [RULE_03] In parallel mode the port B pins are strapped to rails and give the bus address.
// [RULE_04] The SPI port uses phase 1 polarity 1 and samples data on rising clock.
// [RULE_05] The SPI controller keeps its bit rate at or below one megabit per second.
// [RULE_06] Serial data out is only ever driven low and relies on an outside pull-up.
// [RULE_07] In chain mode port B is always a pulse link.
// [RULE_08] In chain mode with SPI on port A, A is slave and B is master.
// [RULE_09] With SPI in a chain the host starts on port A of the first device.
// [RULE_10] In chain mode with pulse port A, the starting port becomes slave.
// [RULE_11] In parallel mode only port A is used, as SPI or pulse link.
// [RULE_12] The pulse link carries select, clock and data as encoded pulses.
// [RULE_13] The master port sends long for select changes and short for data bits.
// [RULE_14] A slave port only returns short -1 for a read 0; silence means 1.
// [RULE_15] In ready state a long -1 on a port makes it slave and the other master.
// [RULE_16] The SPI slave ignores clocks while select is high and clears its bit count on select fall.
// [RULE_17] Straps are sampled and held, never changing mid transaction.
`timescale 1ns/1ps
module serial_port_chain_frontend
    import chain_frontend_pkg::*;
(
    input  wire logic                clock_in,
    input  wire logic                sys_rst_in,
    input  wire logic                clk_en_in,
    input  wire logic                port_a_interface_select_in,
    input  wire logic                chain_topology_select_in,
    input  wire logic                spi_csb_in,
    input  wire logic                spi_sck_in,
    input  wire logic                spi_sdi_in,
    output logic                     spi_sdo_out,
    output logic                     spi_sdo_oe_out,
    input  wire logic                port_a_rx_pos_in,
    input  wire logic                port_a_rx_neg_in,
    output logic                     port_a_tx_pos_out,
    output logic                     port_a_tx_neg_out,
    input  wire logic                port_b_rx_pos_in,
    input  wire logic                port_b_rx_neg_in,
    output logic                     port_b_tx_pos_out,
    output logic                     port_b_tx_neg_out,
    input  wire logic [ADDR_W-1:0]   port_b_strap_in,
    input  wire logic                core_read_valid_in,
    input  wire logic                core_read_bit_in,
    output logic                     core_csb_out,
    output logic                     core_sck_out,
    output logic                     core_sdi_out,
    output logic [BITCNT_W-1:0]      bit_count_out,
    output logic [ADDR_W-1:0]        device_address_out,
    output logic                     chain_mode_out,
    output logic                     iso_mode_out,
    output logic                     slave_is_b_out,
    output logic                     active_out
);
    logic [SYNC_W-1:0] meta_reg;
    logic [SYNC_W-1:0] sync_reg;
    logic              csb_prev_reg;
    logic              sck_prev_reg;
    link_state_t       state_reg;
    logic              resp_zero_reg;

    // Pulse receivers, index 0 is port A, 1 is port B
    rx_state_t         rx_state_reg [2];
    logic [CNT_W-1:0]  rx_cnt_reg   [2];
    logic              rx_neg_reg   [2];
    logic              rx_ev_reg    [2];
    logic              rx_long_reg  [2];
    logic              rx_evneg_reg [2];
    logic [1:0]        rx_pos;
    logic [1:0]        rx_neg;

    pulse_tx_if tx_a ();
    pulse_tx_if tx_b ();

    // Every pin and strap passes two flip-flops
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            meta_reg <= SYNC_RST;
            sync_reg <= SYNC_RST;
        end else if (clk_en_in) begin
            meta_reg <= {port_b_strap_in, port_b_rx_neg_in, port_b_rx_pos_in,
                         port_a_rx_neg_in, port_a_rx_pos_in, spi_sdi_in, spi_sck_in,
                         spi_csb_in, chain_topology_select_in, port_a_interface_select_in};
            sync_reg <= meta_reg;
        end
    end

    assign rx_pos = {sync_reg[SP_BPOS], sync_reg[SP_APOS]};
    assign rx_neg = {sync_reg[SP_BNEG], sync_reg[SP_ANEG]};

    // Pulse type from sign and length of the first level
    generate
        for (genvar p = 0; p < 2; p++) begin : g_rx
            always_ff @(posedge clock_in) begin
                if (sys_rst_in) begin
                    rx_state_reg[p] <= RX_IDLE;
                    rx_cnt_reg[p]   <= CNT_RST;
                    rx_neg_reg[p]   <= 1'b0;
                    rx_ev_reg[p]    <= 1'b0;
                    rx_long_reg[p]  <= 1'b0;
                    rx_evneg_reg[p] <= 1'b0;
                end else if (clk_en_in) begin
                    rx_ev_reg[p] <= 1'b0;
                    unique case (rx_state_reg[p])
                        RX_IDLE: begin
                            if (rx_pos[p] != rx_neg[p]) begin
                                rx_state_reg[p] <= RX_FIRST;
                                rx_neg_reg[p]   <= rx_neg[p];
                                rx_cnt_reg[p]   <= CNT_W'(1);
                            end
                        end
                        RX_FIRST: begin
                            if ((rx_neg_reg[p] ? rx_neg[p] : rx_pos[p])) begin
                                if (rx_cnt_reg[p] != {CNT_W{1'b1}}) begin
                                    rx_cnt_reg[p] <= rx_cnt_reg[p] + 1'b1;
                                end
                            end else begin
                                rx_state_reg[p] <= RX_TAIL;
                                rx_ev_reg[p]    <= 1'b1;
                                rx_evneg_reg[p] <= rx_neg_reg[p];
                                rx_long_reg[p]  <= (rx_cnt_reg[p] >= CNT_W'(LONG_SPLIT_CYC));
                            end
                        end
                        RX_TAIL: begin
                            if (!rx_pos[p] && !rx_neg[p]) begin
                                rx_state_reg[p] <= RX_IDLE;
                            end
                        end
                        default: rx_state_reg[p] <= RX_IDLE;
                    endcase
                end
            end
        end
    endgenerate

    // Decoded events
    wire idle_ready = (state_reg == LINK_READY);
    wire csb_s      = sync_reg[SP_CSB];
    wire sck_s      = sync_reg[SP_SCK];
    // [RULE_01] interface select
    wire spi_mode   = !iso_mode_out;
    // [RULE_16] clocks gated by select
    wire spi_fall   = spi_mode && csb_prev_reg && !csb_s;
    wire spi_rise   = spi_mode && !csb_prev_reg && csb_s;
    wire spi_clk    = spi_mode && !csb_s && !sck_prev_reg && sck_s;
    wire spi_sckf   = spi_mode && !csb_s && sck_prev_reg && !sck_s;
    // [RULE_15] long -1 claims slave role
    wire a_start    = iso_mode_out && idle_ready && rx_ev_reg[0] && rx_long_reg[0]
                      && rx_evneg_reg[0];
    // [RULE_10] port B may start only with pulse port A in a chain
    // [RULE_11] parallel mode watches port A only
    wire b_start    = iso_mode_out && chain_mode_out && idle_ready && !a_start
                      && rx_ev_reg[1] && rx_long_reg[1] && rx_evneg_reg[1];
    wire sl_ev      = slave_is_b_out ? rx_ev_reg[1] : rx_ev_reg[0];
    wire sl_long    = slave_is_b_out ? rx_long_reg[1] : rx_long_reg[0];
    wire sl_neg     = slave_is_b_out ? rx_evneg_reg[1] : rx_evneg_reg[0];
    wire ms_ev      = slave_is_b_out ? rx_ev_reg[0] : rx_ev_reg[1];
    wire ms_long    = slave_is_b_out ? rx_long_reg[0] : rx_long_reg[1];
    wire ms_neg     = slave_is_b_out ? rx_evneg_reg[0] : rx_evneg_reg[1];
    // [RULE_12] pulses stand for select, clock and data
    wire iso_act    = iso_mode_out && active_out && sl_ev;
    wire ev_fall    = spi_fall || a_start || b_start;
    wire ev_rise    = spi_rise || (iso_act && sl_long && !sl_neg);
    wire ev_clk     = spi_clk || (iso_act && !sl_long);
    wire ev_data    = spi_mode ? sync_reg[SP_SDI] : !sl_neg;
    // [RULE_14] downstream short -1 means a 0 bit
    wire ms_zero    = chain_mode_out && active_out && ms_ev && !ms_long && ms_neg;
    wire read_zero  = core_read_valid_in && !core_read_bit_in;
    wire new_slave_b = b_start;

    // [RULE_13] master port encoding
    wire fwd        = chain_mode_out && (ev_fall || ev_rise || ev_clk);
    wire fwd_long   = !ev_clk;
    wire fwd_neg    = ev_fall || (ev_clk && !ev_data);
    wire fwd_to_b   = !(ev_fall ? new_slave_b : slave_is_b_out);
    // [RULE_14] slave replies only short -1
    wire ret        = iso_mode_out && ((ev_clk && read_zero) || ms_zero);

    // [RULE_07] port B always pulse, driven only in chain mode
    assign tx_b.req     = (fwd && fwd_to_b) || (ret && slave_is_b_out);
    assign tx_b.is_long = fwd && fwd_to_b && fwd_long;
    assign tx_b.is_neg  = (fwd && fwd_to_b) ? fwd_neg : 1'b1;
    assign tx_a.req     = (fwd && !fwd_to_b) || (ret && !slave_is_b_out);
    assign tx_a.is_long = fwd && !fwd_to_b && fwd_long;
    assign tx_a.is_neg  = (fwd && !fwd_to_b) ? fwd_neg : 1'b1;

    pulse_tx u_tx_a (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .tx         (tx_a),
        .pos_out    (port_a_tx_pos_out),
        .neg_out    (port_a_tx_neg_out)
    );

    pulse_tx u_tx_b (
        .clock_in   (clock_in),
        .sys_rst_in (sys_rst_in),
        .clk_en_in  (clk_en_in),
        .tx         (tx_b),
        .pos_out    (port_b_tx_pos_out),
        .neg_out    (port_b_tx_neg_out)
    );

    // Link state, roles, straps and internal SPI drive
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            state_reg          <= LINK_READY;
            active_out         <= 1'b0;
            slave_is_b_out     <= 1'b0;
            chain_mode_out     <= 1'b0;
            iso_mode_out       <= 1'b0;
            device_address_out <= '0;
            csb_prev_reg       <= 1'b1;
            sck_prev_reg       <= 1'b1;
            core_csb_out       <= 1'b1;
            core_sck_out       <= 1'b0;
            core_sdi_out       <= 1'b0;
            bit_count_out      <= '0;
            resp_zero_reg      <= 1'b0;
            spi_sdo_oe_out     <= 1'b0;
            spi_sdo_out        <= 1'b0;
        end else if (clk_en_in) begin
            csb_prev_reg <= csb_s;
            sck_prev_reg <= sck_s;
            core_sck_out <= ev_clk;
            // [RULE_17] straps follow the pins only while idle
            if (idle_ready && !ev_fall) begin
                // [RULE_02] topology select
                chain_mode_out <= sync_reg[SP_CHAIN];
                iso_mode_out   <= sync_reg[SP_ISO];
                // [RULE_08] SPI port A leaves port B master
                if (!sync_reg[SP_ISO]) begin
                    slave_is_b_out <= 1'b0;
                end
                // [RULE_03] address from port B straps
                if (!sync_reg[SP_CHAIN]) begin
                    device_address_out <= sync_reg[SP_ADDR +: ADDR_W];
                end
            end
            if (ev_fall) begin
                state_reg      <= LINK_ACTIVE;
                active_out     <= 1'b1;
                // [RULE_08] SPI port A is always slave
                slave_is_b_out <= new_slave_b;
                core_csb_out   <= 1'b0;
                // [RULE_16] bit count clears on select fall
                bit_count_out  <= '0;
            end else if (ev_rise) begin
                state_reg      <= LINK_READY;
                active_out     <= 1'b0;
                core_csb_out   <= 1'b1;
            end
            // [RULE_04] data taken on rising clock
            if (ev_clk) begin
                core_sdi_out  <= ev_data;
                bit_count_out <= bit_count_out + 1'b1;
            end
            // Downstream zero held until next falling clock; set wins
            if (ms_zero && spi_mode) begin
                resp_zero_reg <= 1'b1;
            end else if (spi_sckf || spi_rise) begin
                resp_zero_reg <= 1'b0;
            end
            // [RULE_06] open-drain data out, low only
            if (spi_rise || !spi_mode) begin
                spi_sdo_oe_out <= 1'b0;
            end else if (spi_sckf) begin
                spi_sdo_oe_out <= read_zero || resp_zero_reg;
            end
        end
    end
endmodule

/* File: testbench/serial_port_chain_frontend_sva.sv */
// Port-level assertions for the serial port chain front end
`timescale 1ns/1ps
module serial_port_chain_frontend_sva
    import chain_frontend_pkg::*;
(
    input  wire logic                clock_in,
    input  wire logic                sys_rst_in,
    input  wire logic                spi_csb_in,
    input  wire logic                spi_sck_in,
    input  wire logic                spi_sdo_out,
    input  wire logic                port_a_tx_pos_out,
    input  wire logic                port_a_tx_neg_out,
    input  wire logic                port_b_tx_pos_out,
    input  wire logic                port_b_tx_neg_out,
    input  wire logic                core_csb_out,
    input  wire logic                core_sck_out,
    input  wire logic [BITCNT_W-1:0] bit_count_out,
    input  wire logic                chain_mode_out,
    input  wire logic                iso_mode_out,
    input  wire logic                slave_is_b_out,
    input  wire logic                active_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    a_sdo_low_only: assert property (spi_sdo_out == 1'b0)
        else $error("sdo driven high");
    a_tx_a_levels: assert property (!(port_a_tx_pos_out && port_a_tx_neg_out))
        else $error("port a both levels");
    a_tx_b_levels: assert property (!(port_b_tx_pos_out && port_b_tx_neg_out))
        else $error("port b both levels");
    a_sck_one_cycle: assert property (core_sck_out |=> !core_sck_out)
        else $error("core clock pulse too long");
    a_sck_needs_sel: assert property (core_sck_out |-> !core_csb_out && active_out)
        else $error("clock while deselected");
    a_count_clear: assert property ($fell(core_csb_out) |-> ##[0:1] bit_count_out == 8'h00)
        else $error("bit count not cleared");
    a_modes_held: assert property (active_out && $past(active_out) |->
        $stable(chain_mode_out) && $stable(iso_mode_out) && $stable(slave_is_b_out))
        else $error("mode changed mid transfer");
    a_spi_slave_a: assert property (chain_mode_out && !iso_mode_out |-> !slave_is_b_out)
        else $error("spi chain role wrong");
    a_spi_sel_fall: assert property ($fell(spi_csb_in) && !iso_mode_out |->
        ##[1:5] !core_csb_out)
        else $error("spi select not taken");
    a_spi_sck_rise: assert property ($rose(spi_sck_in) && !iso_mode_out && !core_csb_out
        && !spi_csb_in |-> ##[1:5] core_sck_out)
        else $error("spi clock not taken");
    a_parallel_b_quiet: assert property (!chain_mode_out |->
        !port_b_tx_pos_out && !port_b_tx_neg_out)
        else $error("port b active in parallel");
endmodule
bind serial_port_chain_frontend serial_port_chain_frontend_sva chk (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .spi_csb_in(spi_csb_in), .spi_sck_in(spi_sck_in),
    .spi_sdo_out(spi_sdo_out), .port_a_tx_pos_out(port_a_tx_pos_out),
    .port_a_tx_neg_out(port_a_tx_neg_out), .port_b_tx_pos_out(port_b_tx_pos_out),
    .port_b_tx_neg_out(port_b_tx_neg_out), .core_csb_out(core_csb_out),
    .core_sck_out(core_sck_out), .bit_count_out(bit_count_out),
    .chain_mode_out(chain_mode_out), .iso_mode_out(iso_mode_out),
    .slave_is_b_out(slave_is_b_out), .active_out(active_out));

/* File: testbench/pulse_peer.sv */
// Neighbouring pulse-link port: sends pulses and decodes received ones
`timescale 1ns/1ps
module pulse_peer
    import chain_frontend_pkg::*;
(
    input  wire logic clock_in,
    input  wire logic tx_pos_in,
    input  wire logic tx_neg_in,
    output logic      rx_pos_out,
    output logic      rx_neg_out
);
    logic [5:0]  len       = 6'h00;
    logic        in_first  = 1'b0;
    logic        tail      = 1'b0;
    logic        first_neg = 1'b0;
    logic        last_long = 1'b0;
    logic        last_neg  = 1'b0;
    int unsigned pulses    = 0;
    initial begin
        rx_pos_out = 1'b0;
        rx_neg_out = 1'b0;
    end
    task automatic send(input logic is_long, input logic is_neg);
        int unsigned n;
        n = is_long ? HALF_LONG_CYC : HALF_SHORT_CYC;
        @(posedge clock_in);
        rx_pos_out <= !is_neg;
        rx_neg_out <= is_neg;
        repeat (n) @(posedge clock_in);
        rx_pos_out <= is_neg;
        rx_neg_out <= !is_neg;
        repeat (n) @(posedge clock_in);
        rx_pos_out <= 1'b0; // Released line settles to 0 V
        rx_neg_out <= 1'b0;
    endtask
    // Classify by first level length and sign
    always @(posedge clock_in) begin
        if (tail) begin
            tail <= tx_pos_in || tx_neg_in;
        end else if (!in_first) begin
            if (tx_pos_in || tx_neg_in) begin
                in_first  <= 1'b1;
                first_neg <= tx_neg_in;
                len       <= 6'h01;
            end
        end else if (first_neg ? tx_neg_in : tx_pos_in) begin
            len <= len + 6'h01;
        end else begin
            in_first  <= 1'b0;
            tail      <= 1'b1;
            last_long <= (len >= 6'(LONG_SPLIT_CYC));
            last_neg  <= first_neg;
            pulses    <= pulses + 1;
        end
    end
endmodule

/* File: testbench/serial_port_chain_frontend_tb_top.sv */
// Self-checking bench for the serial port chain front end
`timescale 1ns/1ps
module serial_port_chain_frontend_tb_top;
    import chain_frontend_pkg::*;
    logic clock_in, sys_rst_in, iso_sel, chain_sel, csb, sck, sdi, rd_valid, rd_bit, sdo_seen;
    logic a_rx_pos, a_rx_neg, a_tx_pos, a_tx_neg, b_rx_pos, b_rx_neg, b_tx_pos, b_tx_neg;
    logic spi_sdo, sdo_oe, core_csb, core_sck, core_sdi, chain_mode, iso_mode, slave_b, active;
    logic [ADDR_W-1:0]   strap, dev_addr;
    logic [BITCNT_W-1:0] bit_count;
    int unsigned         failures, total_checks, base;
    serial_port_chain_frontend uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(1'b1), .port_a_interface_select_in(iso_sel),
        .chain_topology_select_in(chain_sel), .spi_csb_in(csb), .spi_sck_in(sck),
        .spi_sdi_in(sdi), .spi_sdo_out(spi_sdo), .spi_sdo_oe_out(sdo_oe),
        .port_a_rx_pos_in(a_rx_pos), .port_a_rx_neg_in(a_rx_neg), .port_a_tx_pos_out(a_tx_pos),
        .port_a_tx_neg_out(a_tx_neg), .port_b_rx_pos_in(b_rx_pos), .port_b_rx_neg_in(b_rx_neg),
        .port_b_tx_pos_out(b_tx_pos), .port_b_tx_neg_out(b_tx_neg), .port_b_strap_in(strap),
        .core_read_valid_in(rd_valid), .core_read_bit_in(rd_bit), .core_csb_out(core_csb),
        .core_sck_out(core_sck), .core_sdi_out(core_sdi), .bit_count_out(bit_count),
        .device_address_out(dev_addr), .chain_mode_out(chain_mode), .iso_mode_out(iso_mode),
        .slave_is_b_out(slave_b), .active_out(active));
    pulse_peer peer_a (.clock_in(clock_in), .tx_pos_in(a_tx_pos), .tx_neg_in(a_tx_neg),
        .rx_pos_out(a_rx_pos), .rx_neg_out(a_rx_neg));
    pulse_peer peer_b (.clock_in(clock_in), .tx_pos_in(b_tx_pos), .tx_neg_in(b_tx_neg),
        .rx_pos_out(b_rx_pos), .rx_neg_out(b_rx_neg));
    // Clock at 100 MHz
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic wait_cyc(input int unsigned n);
        repeat (n) @(posedge clock_in);
    endtask
    // Host opens transfers on port A
    task automatic spi_sel(input logic v);
        @(posedge clock_in);
        csb <= v;
        wait_cyc(40);
    endtask
    // One bit per microsecond, clock idles high
    task automatic spi_bit(input logic d, input logic rd_zero);
        @(posedge clock_in);
        sck      <= 1'b0;
        sdi      <= d;
        rd_valid <= rd_zero;
        rd_bit   <= 1'b0;
        wait_cyc(8);
        sdo_seen = sdo_oe;
        sck <= 1'b1;
        wait_cyc(20);
    endtask
    initial begin
        #50000;
        failures++;
        wrap_up();
    end
    initial begin
        failures = 0;
        total_checks = 0;
        {iso_sel, sdi, rd_valid, rd_bit} = 4'h0;
        {sys_rst_in, chain_sel, csb, sck} = 4'hf;
        strap = 4'h5;
        wait_cyc(3);
        sys_rst_in <= 1'b0;
        wait_cyc(6);
        check({core_csb, active, sdo_oe, chain_mode, iso_mode, slave_b}, 8'h24);
        spi_sel(1'b0);
        check({active, bit_count[6:0]}, 8'h80);
        check({peer_b.pulses[5:0], peer_b.last_long, peer_b.last_neg}, 8'h07);
        // Third bit: downstream short -1 on port B is held onto the data out
        for (int i = 0; i < 3; i++) begin
            if (i == 2) peer_b.send(1'b0, 1'b1);
            spi_bit(i == 0, i == 0);
            check({core_sdi, peer_b.last_long, peer_b.last_neg}, {i == 0, 1'b0, i != 0});
            check(sdo_seen, i != 1);
            wait_cyc(72);
        end
        check(bit_count, 8'h03);
        spi_sel(1'b1);
        check({core_csb, sdo_oe, peer_b.last_long, peer_b.last_neg}, 8'h0a);
        // Clocks with select high must be ignored
        spi_bit(1'b1, 1'b0);
        wait_cyc(20);
        check(bit_count, 8'h03);
        // Pulse mode, transaction started from port B
        iso_sel <= 1'b1;
        wait_cyc(10);
        check(iso_mode, 1'b1);
        peer_b.send(1'b1, 1'b1);
        wait_cyc(40);
        check({slave_b, active, peer_a.last_long, peer_a.last_neg}, 8'h0f);
        base = peer_b.pulses;
        rd_valid <= 1'b1;
        peer_b.send(1'b0, 1'b0);
        wait_cyc(40);
        check({core_sdi, peer_a.last_long, peer_a.last_neg}, 8'h04);
        check({6'(peer_b.pulses - base), peer_b.last_long, peer_b.last_neg}, 8'h05);
        rd_valid <= 1'b0;
        peer_b.send(1'b1, 1'b0);
        wait_cyc(40);
        check({active, core_csb, peer_a.last_long, peer_a.last_neg}, 8'h06);
        // Parallel mode takes the address from the port B pins
        chain_sel <= 1'b0;
        strap     <= 4'ha;
        wait_cyc(10);
        check({chain_mode, dev_addr}, 8'h0a);
        peer_a.send(1'b1, 1'b1);
        wait_cyc(40);
        check({active, slave_b}, 8'h02);
        peer_a.send(1'b1, 1'b0);
        wait_cyc(40);
        check(active, 1'b0);
        wrap_up();
    end
endmodule
